// *** src/mbrb_regbank.sv ***
// Holding-register bank answering serial request frames
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
module mbrb_regbank
  import mbrb_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = `MBRB_GAP_CYC
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rx_i,
  input wire logic [7:0] fault_flags_i,
  input wire logic [15:0] batch_i,
  input wire logic [15:0] serial_i,
  output logic tx_o,
  output logic tx_en_o,
  output logic [15:0] out_config_o,
  output logic [15:0] range_low_o,
  output logic [15:0] range_high_o,
  output logic [15:0] pressure_o,
  output logic [31:0] sensor_id_o,
  output var mbrb_param_t param_code_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mbrb_ser_if ser();
  mbrb_state_t state;
  logic [15:0] node_address;
  logic [15:0] fault_status;
  logic [15:0] output_config;
  logic [15:0] range_low_limit;
  logic [15:0] range_high_limit;
  logic [15:0] calibration_year;
  logic [15:0] calibration_month_day;
  logic [15:0] ppm_pressure_value;
  logic [7:0] frame_buf [0:`MBRB_BUF_LEN-1];
  logic [5:0] rx_cnt;
  logic rx_ovf;
  logic [15:0] rx_crc;
  logic [31:0] gap_cnt;
  logic frame_good;
  logic [7:0] fcode;
  logic [7:0] exc;
  logic [15:0] start_addr;
  logic [15:0] req_qty;
  logic [3:0] qty;
  logic [3:0] idx;
  logic is_rd;
  logic [1:0] kind;
  logic [3:0] rd_idx;
  logic [5:0] tx_rel;
  logic [15:0] rd_addr;
  logic [15:0] rd_data;
  logic [15:0] wr_data;
  logic [5:0] tx_cnt;
  logic [5:0] tx_len;
  logic [15:0] tx_crc;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_last;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One byte through the frame check sequence
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
    input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `MBRB_CRC_POLY) : (c >> 1);
    return c;
  endfunction

  // Map bit and write bit of an offset
  function automatic logic [1:0] reg_kind(input logic [15:0] a);
    case (a)
      `MBRB_NODE_OFS, `MBRB_OCFG_OFS, `MBRB_RLO_OFS, `MBRB_RHI_OFS,
      `MBRB_YEAR_OFS, `MBRB_MDAY_OFS, `MBRB_PRES_OFS:
        return 2'b11;
      `MBRB_FAULT_OFS, `MBRB_FW_OFS, `MBRB_BATCH_OFS,
      `MBRB_SERIAL_OFS:
        return 2'b10;
      default:
        return 2'b00;
    endcase
  endfunction

  // Every nibble a decimal digit
  function automatic logic bcd_ok(input logic [15:0] d);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
      if (d[4*i +: 4] > 4'h9)
        ok = 1'b0;
    return ok;
  endfunction

  // Value check for registers with a restricted range
  function automatic logic value_ok(input logic [15:0] a,
    input logic [15:0] d);
    case (a)
      `MBRB_NODE_OFS:
        return d[15:8] == 8'h00 && d[7:0] != 8'h00;
      `MBRB_YEAR_OFS:
        return bcd_ok(d);
      `MBRB_MDAY_OFS:
        return bcd_ok(d) && d[15:12] == 4'h0;
      default:
        return 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Serial shifters
  // ----------------------------------------------------------------
  mbrb_uart_rx u_rx (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .rx_i(rx_i),
    .ser(ser.rxp)
  );

  mbrb_uart_tx u_tx (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ser(ser.txp),
    .tx_o(tx_o),
    .tx_en_o(tx_en_o)
  );

  assign ser.tx_valid = tx_valid;
  assign ser.tx_data = tx_byte;

  // ----------------------------------------------------------------
  // Frame reception
  // ----------------------------------------------------------------
  // Good frame: long enough, check sums to zero, our address
  assign frame_good = rx_cnt >= 6'd4 && !rx_ovf && rx_crc == 16'h0000
    && frame_buf[0] == node_address[7:0];

  // Collect bytes until the line falls silent
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || state == ST_SEND)
    begin
      rx_cnt <= 6'd0;
      rx_ovf <= 1'b0;
      rx_crc <= `MBRB_CRC_INIT;
      gap_cnt <= 32'h00000000;
    end
    else if (state == ST_RX)
    begin
      if (ser.rx_valid)
      begin
        if (rx_cnt < 6'(`MBRB_BUF_LEN))
        begin
          frame_buf[rx_cnt[4:0]] <= ser.rx_data;
          rx_cnt <= rx_cnt + 6'd1;
        end
        else
          rx_ovf <= 1'b1;
        rx_crc <= crc_step(rx_crc, ser.rx_data);
        gap_cnt <= 32'h00000000;
      end
      else if (rx_cnt != 6'd0 && gap_cnt < GAP_CYCLES - 1)
        gap_cnt <= gap_cnt + 32'h00000001;
      else if (rx_cnt != 6'd0 && !frame_good)
      begin
        rx_cnt <= 6'd0; // Foreign or damaged frame is dropped
        rx_ovf <= 1'b0;
        rx_crc <= `MBRB_CRC_INIT;
        gap_cnt <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request decode and register walk
  // ----------------------------------------------------------------
  assign req_qty = {frame_buf[4], frame_buf[5]};
  assign is_rd = fcode == `MBRB_FC_RD;
  assign kind = reg_kind(rd_addr);
  assign tx_rel = tx_cnt - 6'd3;
  assign rd_idx = (state == ST_SEND) ? tx_rel[4:1] : idx;
  assign rd_addr = start_addr + {12'h000, rd_idx};
  assign wr_data = (fcode == `MBRB_FC_WR1) ? req_qty :
    {frame_buf[5'd7 + {idx, 1'b0}], frame_buf[5'd8 + {idx, 1'b0}]};

  // Sequencer: decode, check every register, write, reply
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_RX;
      fcode <= 8'h00;
      exc <= 8'h00;
      start_addr <= 16'h0000;
      qty <= 4'h0;
      idx <= 4'h0;
    end
    else
    begin
      case (state)
        ST_RX:
          if (!ser.rx_valid && rx_cnt != 6'd0 && gap_cnt >= GAP_CYCLES - 1
            && frame_good)
          begin
            state <= ST_DECODE;
            exc <= 8'h00;
          end
        ST_DECODE:
        begin
          fcode <= frame_buf[1];
          start_addr <= {frame_buf[2], frame_buf[3]};
          qty <= req_qty[3:0];
          idx <= 4'h0;
          state <= ST_CHECK;
          case (frame_buf[1])
            `MBRB_FC_RD:
              if (req_qty == 16'h0000 || req_qty > `MBRB_MAX_QTY
                || rx_cnt != 6'd8)
                exc <= `MBRB_EXC_VAL;
            `MBRB_FC_WR1:
            begin
              qty <= 4'h1;
              if (rx_cnt != 6'd8)
                exc <= `MBRB_EXC_VAL;
            end
            `MBRB_FC_WRN:
              if (req_qty == 16'h0000 || req_qty > `MBRB_MAX_QTY
                || frame_buf[6] != {req_qty[6:0], 1'b0}
                || rx_cnt != 6'd9 + {1'b0, req_qty[3:0], 1'b0})
                exc <= `MBRB_EXC_VAL;
            default:
              exc <= `MBRB_EXC_FUNC;
          endcase
        end
        ST_CHECK:
          if (exc != 8'h00)
            state <= ST_SEND;
          else if (!kind[1] || (!is_rd && !kind[0]))
          begin
            exc <= `MBRB_EXC_ADDR;
            state <= ST_SEND;
          end
          else if (!is_rd && !value_ok(rd_addr, wr_data))
          begin
            exc <= `MBRB_EXC_VAL;
            state <= ST_SEND;
          end
          else if (idx == qty - 4'h1)
          begin
            idx <= 4'h0;
            state <= is_rd ? ST_SEND : ST_WRITE;
          end
          else
            idx <= idx + 4'h1;
        ST_WRITE:
          if (idx == qty - 4'h1)
            state <= ST_SEND;
          else
            idx <= idx + 4'h1;
        ST_SEND:
          if (tx_last)
            state <= ST_RX;
        default:
          state <= ST_RX;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software writes, applied only after the whole request checked out
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      node_address <= `MBRB_NODE_RST;
      output_config <= `MBRB_OCFG_RST;
      range_low_limit <= 16'h0000;
      range_high_limit <= 16'h0000;
      calibration_year <= 16'h0000;
      calibration_month_day <= 16'h0000;
      ppm_pressure_value <= 16'h0000;
    end
    else if (state == ST_WRITE)
    begin
      case (rd_addr)
        `MBRB_NODE_OFS: node_address <= wr_data;
        `MBRB_OCFG_OFS: output_config <= wr_data;
        `MBRB_RLO_OFS: range_low_limit <= wr_data;
        `MBRB_RHI_OFS: range_high_limit <= wr_data;
        `MBRB_YEAR_OFS: calibration_year <= wr_data;
        `MBRB_MDAY_OFS: calibration_month_day <= wr_data;
        `MBRB_PRES_OFS: ppm_pressure_value <= wr_data;
        default: ;
      endcase
    end
  end

  // Live fault flags, sensor short upward
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      fault_status <= 16'h0000;
    else
      fault_status <= {8'h00, fault_flags_i};
  end

  // Read multiplexer; batch then serial form one 32-bit pair
  always_comb
  begin
    case (rd_addr)
      `MBRB_NODE_OFS: rd_data = node_address;
      `MBRB_FAULT_OFS: rd_data = fault_status;
      `MBRB_OCFG_OFS: rd_data = output_config;
      `MBRB_FW_OFS: rd_data = `MBRB_FW_REV;
      `MBRB_RLO_OFS: rd_data = range_low_limit;
      `MBRB_RHI_OFS: rd_data = range_high_limit;
      `MBRB_BATCH_OFS: rd_data = batch_i;
      `MBRB_SERIAL_OFS: rd_data = serial_i;
      `MBRB_YEAR_OFS: rd_data = calibration_year;
      `MBRB_MDAY_OFS: rd_data = calibration_month_day;
      `MBRB_PRES_OFS: rd_data = ppm_pressure_value;
      default: rd_data = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Reply transmission
  // ----------------------------------------------------------------
  assign tx_len = (exc != 8'h00) ? 6'd5 :
    is_rd ? 6'd5 + {1'b0, qty, 1'b0} : 6'd8;
  assign tx_last = tx_valid && ser.tx_ready && tx_cnt == tx_len - 6'd1;

  // Reply byte for the current position; check sequence last
  always_comb
  begin
    if (tx_cnt == tx_len - 6'd2)
      tx_byte = tx_crc[7:0];
    else if (tx_cnt == tx_len - 6'd1)
      tx_byte = tx_crc[15:8];
    else if (tx_cnt == 6'd0)
      tx_byte = frame_buf[0];
    else if (tx_cnt == 6'd1)
      tx_byte = (exc != 8'h00) ? (fcode | `MBRB_EXC_FLAG) : fcode;
    else if (exc != 8'h00)
      tx_byte = exc;
    else if (is_rd && tx_cnt == 6'd2)
      tx_byte = {3'b000, qty, 1'b0};
    else if (is_rd)
      tx_byte = tx_cnt[0] ? rd_data[15:8] : rd_data[7:0];
    else
      tx_byte = frame_buf[tx_cnt[4:0]]; // Echo of address and count, or of address and value for a single write
  end

  // Hand bytes to the transmitter one at a time
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || state != ST_SEND)
    begin
      tx_valid <= 1'b0;
      tx_cnt <= 6'd0;
      tx_crc <= `MBRB_CRC_INIT;
    end
    else if (tx_valid && ser.tx_ready)
    begin
      tx_valid <= 1'b0;
      tx_cnt <= tx_cnt + 6'd1;
      if (tx_cnt < tx_len - 6'd2)
        tx_crc <= crc_step(tx_crc, tx_byte);
    end
    else if (!tx_valid)
      tx_valid <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Outputs to the loop-current and measurement logic
  // ----------------------------------------------------------------
  assign out_config_o = output_config;
  assign range_low_o = range_low_limit;
  assign range_high_o = range_high_limit;
  assign pressure_o = ppm_pressure_value;

  // Parameter code; one bit expected, highest wins otherwise
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      param_code_o <= PAR_DEW;
      sensor_id_o <= 32'h00000000;
    end
    else
    begin
      sensor_id_o <= {batch_i, serial_i};
      if (output_config[`MBRB_OC_GAS_BIT])
        param_code_o <= PAR_GAS;
      else if (output_config[`MBRB_OC_PPMW_BIT])
        param_code_o <= PAR_PPMW;
      else if (output_config[`MBRB_OC_PPMV_BIT])
        param_code_o <= PAR_PPMV;
      else if (output_config[`MBRB_OC_TEMP_BIT])
        param_code_o <= PAR_TEMP;
      else
        param_code_o <= PAR_DEW;
    end
  end
endmodule
`default_nettype wire

// *** inc/mbrb_consts.svh ***
// Constants for the serial holding-register bank
`ifndef MBRB_CONSTS_SVH
`define MBRB_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MBRB_CLK_HZ 20000000
`define MBRB_BAUD 9600
`define MBRB_BIT_CYC (`MBRB_CLK_HZ / `MBRB_BAUD)
`define MBRB_HALF_CYC (`MBRB_BIT_CYC / 2)
`define MBRB_GAP_US 4010
`define MBRB_GAP_CYC (`MBRB_GAP_US * (`MBRB_CLK_HZ / 1000000))

// ----------------------------------------------------------------
// Frame handling
// ----------------------------------------------------------------
`define MBRB_BUF_LEN 32
`define MBRB_MAX_QTY 16'h0008
`define MBRB_CRC_INIT 16'hFFFF
`define MBRB_CRC_POLY 16'hA001
`define MBRB_FC_RD 8'h03
`define MBRB_FC_WR1 8'h06
`define MBRB_FC_WRN 8'h10
`define MBRB_EXC_FLAG 8'h80
`define MBRB_EXC_FUNC 8'h01
`define MBRB_EXC_ADDR 8'h02
`define MBRB_EXC_VAL 8'h03

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MBRB_NODE_OFS 16'h0000
`define MBRB_FAULT_OFS 16'h0003
`define MBRB_OCFG_OFS 16'h0004
`define MBRB_FW_OFS 16'h0008
`define MBRB_RLO_OFS 16'h000A
`define MBRB_RHI_OFS 16'h000B
`define MBRB_BATCH_OFS 16'h000F
`define MBRB_SERIAL_OFS 16'h0010
`define MBRB_YEAR_OFS 16'h0011
`define MBRB_MDAY_OFS 16'h0012
`define MBRB_PRES_OFS 16'h0036

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define MBRB_NODE_RST 16'h0001
`define MBRB_OCFG_RST 16'h0214
`define MBRB_FW_REV 16'h0203
`define MBRB_OC_FLT_LSB 0
`define MBRB_OC_UND_LSB 4
`define MBRB_OC_OVR_LSB 8
`define MBRB_OC_TEMP_BIT 12
`define MBRB_OC_PPMV_BIT 13
`define MBRB_OC_PPMW_BIT 14
`define MBRB_OC_GAS_BIT 15

`endif

// *** inc/mbrb_pkg.sv ***
// Types shared by the serial holding-register bank
`default_nettype none
package mbrb_pkg;
  typedef enum {ST_RX, ST_DECODE, ST_CHECK, ST_WRITE, ST_SEND}
    mbrb_state_t;
  typedef enum logic [2:0] {PAR_DEW, PAR_TEMP, PAR_PPMV, PAR_PPMW,
    PAR_GAS} mbrb_param_t;
endpackage
`default_nettype wire

// *** inc/mbrb_ser_if.sv ***
// Byte stream between the frame engine and the serial shifters
`timescale 1ns/1ps
`default_nettype none
interface mbrb_ser_if;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  modport rxp (output rx_valid, output rx_data);
  modport txp (input tx_valid, input tx_data, output tx_ready);
  modport core (input rx_valid, input rx_data, input tx_ready,
    output tx_valid, output tx_data);
endinterface
`default_nettype wire

// *** src/mbrb_uart_rx.sv ***
// Serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
module mbrb_uart_rx
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rx_i,
  mbrb_ser_if.rxp ser
);
  logic sync1;
  logic sync2;
  logic busy;
  logic [11:0] cyc;
  logic [3:0] bit_idx;
  logic [7:0] shreg;

  // Two-stage synchroniser for the line
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end
    else
    begin
      sync1 <= rx_i;
      sync2 <= sync1;
    end
  end

  // Bit timing, centre sampling and stop check
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      busy <= 1'b0;
      cyc <= 12'h000;
      bit_idx <= 4'h0;
      shreg <= 8'h00;
      ser.rx_valid <= 1'b0;
      ser.rx_data <= 8'h00;
    end
    else
    begin
      ser.rx_valid <= 1'b0;
      if (!busy)
      begin
        if (!sync2)
        begin
          busy <= 1'b1;
          cyc <= 12'(`MBRB_HALF_CYC);
          bit_idx <= 4'h0;
        end
      end
      else if (cyc != 12'h000)
        cyc <= cyc - 12'h001;
      else
      begin
        cyc <= 12'(`MBRB_BIT_CYC - 1);
        if (bit_idx == 4'h0)
        begin
          busy <= !sync2; // False start drops out
          bit_idx <= 4'h1;
        end
        else if (bit_idx <= 4'h8)
        begin
          shreg <= {sync2, shreg[7:1]}; // LSB first
          bit_idx <= bit_idx + 4'h1;
        end
        else
        begin
          busy <= 1'b0;
          ser.rx_valid <= sync2; // Bad stop bit loses the byte
          ser.rx_data <= shreg;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** src/mbrb_uart_tx.sv ***
// Serial transmitter with line-driver enable
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
module mbrb_uart_tx
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  mbrb_ser_if.txp ser,
  output logic tx_o,
  output logic tx_en_o
);
  logic busy;
  logic [11:0] cyc;
  logic [3:0] bit_idx;
  logic [9:0] shreg;

  assign ser.tx_ready = !busy;

  // Start, 8 data, stop; driver stays on while bytes follow
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      busy <= 1'b0;
      cyc <= 12'h000;
      bit_idx <= 4'h0;
      shreg <= 10'h3FF;
      tx_o <= 1'b1;
      tx_en_o <= 1'b0;
    end
    else if (!busy)
    begin
      if (ser.tx_valid)
      begin
        shreg <= {1'b1, ser.tx_data, 1'b0};
        busy <= 1'b1;
        cyc <= 12'(`MBRB_BIT_CYC - 1);
        bit_idx <= 4'h0;
        tx_o <= 1'b0;
        tx_en_o <= 1'b1;
      end
      else
        tx_en_o <= 1'b0;
    end
    else if (cyc != 12'h000)
      cyc <= cyc - 12'h001;
    else if (bit_idx == 4'h9)
      busy <= 1'b0;
    else
    begin
      shreg <= {1'b1, shreg[9:1]};
      tx_o <= shreg[1];
      bit_idx <= bit_idx + 4'h1;
      cyc <= 12'(`MBRB_BIT_CYC - 1);
    end
  end
endmodule
`default_nettype wire

// *** test/mbrb_regbank_assertions.sv ***
// Port checks for the serial holding-register bank
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
module mbrb_regbank_assertions
  import mbrb_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = `MBRB_GAP_CYC
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] batch_i,
  input wire logic [15:0] serial_i,
  input wire logic tx_o,
  input wire logic tx_en_o,
  input wire logic [15:0] out_config_o,
  input wire logic [15:0] range_low_o,
  input wire logic [15:0] range_high_o,
  input wire logic [31:0] sensor_id_o,
  input wire mbrb_param_t param_code_o
);
  localparam int BIT = `MBRB_BIT_CYC;
  int run_cnt;
  logic prev_tx;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------
  // Cycles since the transmit line last moved
  // ------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    prev_tx <= tx_o;
    if (sys_rst_i || tx_o != prev_tx)
      run_cnt <= 0;
    else
      run_cnt <= run_cnt + 1;
  end
  chk_sensor_id_join:
    assert property (!$past(sys_rst_i) |->
      sensor_id_o == {$past(batch_i), $past(serial_i)})
    else $error("sensor identity not batch then serial");
  chk_param_dew_default:
    assert property ($stable(out_config_o) && out_config_o[15:12] == 4'h0
      |-> param_code_o == PAR_DEW)
    else $error("no parameter bit but not dew point");
  chk_param_gas_top:
    assert property ($stable(out_config_o) && out_config_o[15]
      |-> param_code_o == PAR_GAS)
    else $error("top parameter bit not gas");
  chk_param_temp_only:
    assert property ($stable(out_config_o) && out_config_o[15:12] == 4'h1
      |-> param_code_o == PAR_TEMP)
    else $error("lowest parameter bit not temperature");
  chk_idle_line_high:
    assert property (!tx_en_o |-> tx_o)
    else $error("line low with driver off");
  chk_bit_spacing:
    assert property ((tx_o != prev_tx) && tx_en_o |-> run_cnt >= BIT - 2)
    else $error("reply bit shorter than one baud period");
  chk_en_release:
    assert property ($fell(tx_en_o) |-> tx_o && $past(tx_o))
    else $error("driver released outside stop level");
  chk_range_quiet_tx:
    assert property ($changed(range_low_o) || $changed(range_high_o)
      |-> !tx_en_o)
    else $error("range limit changed during a reply");
endmodule
`default_nettype wire

// *** test/mbrb_master.sv ***
// Serial master model that frames requests and gathers reply bytes
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
module mbrb_master
(
  input wire logic core_clk_i,
  input wire logic tx_i,
  input wire logic tx_en_i,
  output logic rx_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  localparam int BIT = `MBRB_BIT_CYC;
  logic [7:0] d;
  initial rx_o = 1'b1;
  initial got_o = 1'b0;
  initial got_byte_o = 8'h00;
  // Frame check word over a byte list, low byte sent first
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // Shifts a request out LSB first at 9600 baud, 8N1
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [9:0] sh;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      sh = {1'b1, q[i], 1'b0};
      for (int b = 0; b < 10; b++)
      begin
        @(posedge core_clk_i);
        rx_o <= sh[b];
        repeat (BIT - 1) @(posedge core_clk_i);
      end
    end
  endtask
  // Samples each reply byte at its bit centres, stop must be high
  always
  begin
    @(posedge core_clk_i);
    got_o <= 1'b0;
    if (tx_en_i && !tx_i)
    begin
      repeat (BIT / 2) @(posedge core_clk_i);
      for (int b = 0; b < 8; b++)
      begin
        repeat (BIT) @(posedge core_clk_i);
        d[b] = tx_i;
      end
      repeat (BIT) @(posedge core_clk_i);
      got_byte_o <= d;
      got_o <= tx_i;
    end
  end
endmodule
`default_nettype wire

// *** test/modbus_rtu_register_bank_tb_top.sv ***
// Self-checking bench for the serial holding-register bank
`timescale 1ns/1ps
`default_nettype none
`include "mbrb_consts.svh"
`define CHECK(nm, ex, sn) \
  begin \
    num_checks++; \
    if ((sn) !== (ex)) \
    begin \
      failures++; \
      $display("[ERR] %s exp %h seen %h", nm, ex, sn); \
    end \
  end
module modbus_rtu_register_bank_tb_top;
  import mbrb_pkg::*;
  localparam int BIT = `MBRB_BIT_CYC;
  // Silence limit must outlast one whole character on the line
  localparam int GAP = 11 * BIT;
  localparam logic [7:0] ND = 8'h01;
  logic core_clk, sys_rst, rx, tx, tx_en, got;
  logic [7:0] fault_flags, got_byte, e;
  logic [15:0] batch, serial, out_config, range_low, range_high;
  logic [15:0] pressure, pv;
  logic [31:0] sensor_id;
  mbrb_param_t param_code;
  logic [7:0] exp_q[$];
  logic [7:0] none[$];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  mbrb_regbank #(.GAP_CYCLES(GAP)) i_mbrb_regbank (.core_clk_i(core_clk),
    .sys_rst_i(sys_rst), .rx_i(rx), .fault_flags_i(fault_flags),
    .batch_i(batch), .serial_i(serial), .tx_o(tx), .tx_en_o(tx_en),
    .out_config_o(out_config), .range_low_o(range_low),
    .range_high_o(range_high), .pressure_o(pressure),
    .sensor_id_o(sensor_id), .param_code_o(param_code));
  mbrb_master i_mbrb_master (.core_clk_i(core_clk), .tx_i(tx),
    .tx_en_i(tx_en), .rx_o(rx), .got_o(got), .got_byte_o(got_byte));
  // Clock at 20 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Notes the reply a request should draw, sends it, waits it out
  task automatic run(input logic [7:0] rq[$], input logic [7:0] rs[$]);
    logic [15:0] c;
    c = i_mbrb_master.crc16(rs);
    if (rs.size() != 0)
      exp_q = {exp_q, rs, c[7:0], c[15:8]};
    i_mbrb_master.send(rq);
    for (int i = 0; i < 300000 && exp_q.size() != 0; i++)
      @(posedge core_clk);
    `CHECK("reply left", 0, exp_q.size())
    // Let the frame gap expire so the next request starts a new frame
    repeat (GAP) @(posedge core_clk);
  endtask
  // Compares each reply byte with the oldest note
  always @(posedge core_clk)
    if (got)
    begin
      if (exp_q.size() == 0)
        `CHECK("extra byte", 1'b0, 1'b1)
      else
      begin
        e = exp_q.pop_front();
        `CHECK("reply byte", e, got_byte)
      end
    end
  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000000)
    begin
      failures++;
      complete_run();
    end
  end
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    fault_flags = 8'h00;
    batch = 16'h0000;
    serial = 16'h0000;
    void'($urandom(64581));
    pv = 16'($urandom());
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    fault_flags <= 8'($urandom());
    batch <= 16'($urandom());
    serial <= 16'($urandom());
    @(posedge core_clk);
    run('{ND, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h04, 8'hFC, 8'h18,
      8'h00, 8'hC8}, '{ND, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h02});
    `CHECK("range low", 16'hFC18, range_low)
    `CHECK("range high", 16'h00C8, range_high)
    run('{ND, 8'h03, 8'h00, 8'h03, 8'h00, 8'h02}, '{ND, 8'h03, 8'h04,
      8'h00, fault_flags, 8'h02, 8'h14});
    // One current per field in all three settings
    run('{ND, 8'h06, 8'h00, 8'h04, 8'h11, 8'h24},
      '{ND, 8'h06, 8'h00, 8'h04, 8'h11, 8'h24});
    `CHECK("config", 16'h1124, out_config)
    `CHECK("param", PAR_TEMP, param_code)
    run('{ND, 8'h06, 8'h00, 8'h04, 8'h82, 8'h14},
      '{ND, 8'h06, 8'h00, 8'h04, 8'h82, 8'h14});
    `CHECK("param", PAR_GAS, param_code)
    run('{ND, 8'h06, 8'h00, 8'h36, pv[15:8], pv[7:0]},
      '{ND, 8'h06, 8'h00, 8'h36, pv[15:8], pv[7:0]});
    `CHECK("pressure", pv, pressure)
    run('{ND, 8'h06, 8'h00, 8'h04, 8'h22, 8'h14},
      '{ND, 8'h06, 8'h00, 8'h04, 8'h22, 8'h14});
    `CHECK("param", PAR_PPMV, param_code)
    // Calibration date in decimal digits, written then read back
    run('{ND, 8'h10, 8'h00, 8'h11, 8'h00, 8'h02, 8'h04, 8'h20, 8'h18,
      8'h03, 8'h17}, '{ND, 8'h10, 8'h00, 8'h11, 8'h00, 8'h02});
    run('{ND, 8'h03, 8'h00, 8'h11, 8'h00, 8'h02}, '{ND, 8'h03, 8'h04,
      8'h20, 8'h18, 8'h03, 8'h17});
    run('{ND, 8'h06, 8'h00, 8'h08, 8'h00, 8'h01},
      '{ND, 8'h86, 8'h02});
    run('{ND, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
      '{ND, 8'h84, 8'h01});
    run('{ND, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00},
      '{ND, 8'h86, 8'h03});
    run('{8'h07, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, none);
    run('{ND, 8'h03, 8'h00, 8'h0F, 8'h00, 8'h02}, '{ND, 8'h03, 8'h04,
      batch[15:8], batch[7:0], serial[15:8], serial[7:0]});
    `CHECK("sensor id", {batch, serial}, sensor_id)
    complete_run();
  end
endmodule
bind mbrb_regbank mbrb_regbank_assertions #(.GAP_CYCLES(GAP_CYCLES))
  i_mbrb_regbank_assertions (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .batch_i(batch_i), .serial_i(serial_i),
  .tx_o(tx_o), .tx_en_o(tx_en_o), .out_config_o(out_config_o),
  .range_low_o(range_low_o), .range_high_o(range_high_o),
  .sensor_id_o(sensor_id_o), .param_code_o(param_code_o));
`default_nettype wire
